// File: verif/cache_ctrl_model.sv
// Cache-controller model that drives the memory's synchronous pins
`timescale 1ns/1ps
module cache_ctrl_model (
  input  logic        ref_clk,
  input  logic [17:0] dataOut,
  input  logic        dataOutEnable,
  output logic [16:0] address,
  output logic [17:0] dataIn,
  output logic        processor_addr_strobe_n,
  output logic        controller_addr_strobe_n,
  output logic        burst_advance_n,
  output logic        global_write_n,
  output logic        byte_write_enable_n,
  output logic [1:0]  lane_write_select_n,
  output logic        chip_select_first_n,
  output logic        chip_select_second,
  output logic        chip_select_third_n
);
  logic [17:0] drvData;
  logic        drvOn;

  // A released wire shows the inverse of the memory's output register, never a stale copy
  assign dataIn = dataOutEnable ? dataOut : (drvOn ? drvData : ~dataOut);

  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
    {burst_advance_n, global_write_n, byte_write_enable_n} = 3'h7;
    lane_write_select_n = 2'h3;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
    address = '0;
    drvData = '0;
    drvOn   = 1'b0;
  end

  // Pins change just after the edge and hold for the whole cycle
  task automatic cycle(input logic p, c, stepN, allN, byteN,
                       input logic [1:0] ln, input logic [2:0] ce,
                       input logic [16:0] a, input logic [17:0] d);
    @(posedge ref_clk);
    processor_addr_strobe_n  <= p;
    controller_addr_strobe_n <= c;
    burst_advance_n          <= stepN;
    global_write_n           <= allN;
    byte_write_enable_n      <= byteN;
    lane_write_select_n      <= ln;
    {chip_select_first_n, chip_select_second, chip_select_third_n} <= ce;
    address <= a;
    drvData <= d;
    drvOn   <= ~(allN & byteN);
  endtask

  // Strobe with the device unselected ends any running burst
  task automatic desel();
    cycle(1, 0, 1, 1, 1, 2'h3, 3'h0, ~address, '0);
  endtask

  task automatic idle();
    cycle(1, 1, 1, 1, 1, 2'h3, 3'h2, ~address, '0);
  endtask
endmodule

// File: verif/sync_burst_sram_tb.sv
// Self-checking bench for the pipelined burst memory
`timescale 1ns/1ps
module sync_burst_sram_tb;
  localparam logic [2:0]  SEL  = 3'h2;
  localparam logic [16:0] BASE = 17'h1_5A4C;
  localparam logic [17:0] BAD  = 18'h1_2345;
  logic        ref_clk, nrst, burstOrderStrap, outputEnableN, sleep_request;
  logic [16:0] address;
  logic [17:0] dataIn, dataOut, shadow [4], v;
  logic        dataOutEnable, pStrobeN, cStrobeN, advanceN, globalWriteN;
  logic        byteWriteN;
  logic [1:0]  laneN;
  logic        selFirstN, selSecond, selThirdN;
  int          errCount, nCompared;

  sync_burst_sram sync_burst_sram_inst (
    .ref_clk(ref_clk), .nrst(nrst), .address(address), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEnable(dataOutEnable),
    .processor_addr_strobe_n(pStrobeN), .controller_addr_strobe_n(cStrobeN),
    .burst_advance_n(advanceN), .global_write_n(globalWriteN),
    .byte_write_enable_n(byteWriteN), .lane_write_select_n(laneN),
    .chip_select_first_n(selFirstN), .chip_select_second(selSecond),
    .chip_select_third_n(selThirdN), .outputEnableN(outputEnableN),
    .sleep_request(sleep_request), .burstOrderStrap(burstOrderStrap)
  );

  cache_ctrl_model cache_ctrl_model_inst (
    .ref_clk(ref_clk), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
    .address(address), .dataIn(dataIn),
    .processor_addr_strobe_n(pStrobeN), .controller_addr_strobe_n(cStrobeN),
    .burst_advance_n(advanceN), .global_write_n(globalWriteN),
    .byte_write_enable_n(byteWriteN), .lane_write_select_n(laneN),
    .chip_select_first_n(selFirstN), .chip_select_second(selSecond),
    .chip_select_third_n(selThirdN)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic check(input string nm, input logic [17:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (errCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    nrst            <= 1'b0;
    burstOrderStrap <= strap;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) cache_ctrl_model_inst.idle();
  endtask

  task automatic wr(input logic [16:0] a, input logic allN, byteN,
                    input logic [1:0] ln, input logic [17:0] d);
    cache_ctrl_model_inst.cycle(1, 0, 1, allN, byteN, ln, SEL, a, d);
    cache_ctrl_model_inst.desel();
  endtask

  // Single read; idles after sampling so the drivers are off again
  task automatic rd(input logic [16:0] a, output logic [17:0] q);
    cache_ctrl_model_inst.cycle(1, 0, 1, 1, 1, 2'h3, SEL, a, '0);
    cache_ctrl_model_inst.desel();
    repeat (2) cache_ctrl_model_inst.idle();
    #1;
    q = dataOut;
    repeat (2) cache_ctrl_model_inst.idle();
  endtask

  // Four-beat read from low bits 01, ended by a deselect
  task automatic burst(input logic [2:0] steps, input logic [1:0] seq [4],
                       input string nm);
    cache_ctrl_model_inst.cycle(1, 0, 1, 1, 1, 2'h3, SEL, BASE + 1, '0);
    for (int i = 0; i < 8; i++) begin
      if (i < 3) begin
        cache_ctrl_model_inst.cycle(1, 1, steps[i], 1, 1, 2'h3, SEL, ~BASE,
                                    '0);
      end else if (i == 3) begin
        cache_ctrl_model_inst.desel();
      end else begin
        cache_ctrl_model_inst.idle();
      end
      #1;
      check({nm, " drive"}, 18'(dataOutEnable), 18'(i >= 2 && i < 7));
      if (i >= 2 && i < 6) begin
        check({nm, " word"}, dataOut, shadow[seq[i-2]]);
      end
      if (i == 3) begin
        outputEnableN = 1'b1;
        #1;
        check({nm, " oe off"}, 18'(dataOutEnable), 18'h0_0000);
        outputEnableN = 1'b0;
      end
    end
  endtask

  task automatic byte_lanes();
    wr(BASE, 1, 0, 2'h2, 18'h3_FFFF);
    shadow[0][8:0] = 9'h1FF;
    wr(BASE + 2, 1, 0, 2'h1, 18'h0_0000);
    shadow[2][17:9] = 9'h000;
    wr(BASE + 3, 1, 1, 2'h0, 18'h0_0000);
    for (int i = 0; i < 4; i++) begin
      rd(BASE + 17'(i), v);
      check("lane word", v, shadow[i]);
    end
  endtask

  task automatic refused();
    logic [2:0] ce [3];
    ce = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      cache_ctrl_model_inst.cycle(1, 0, 1, 0, 1, 2'h3, ce[i], BASE, BAD);
      cache_ctrl_model_inst.desel();
    end
    cache_ctrl_model_inst.cycle(0, 1, 1, 0, 1, 2'h3, 3'h6, BASE, BAD);
    cache_ctrl_model_inst.desel();
    cache_ctrl_model_inst.cycle(0, 0, 1, 0, 1, 2'h3, SEL, BASE, BAD);
    cache_ctrl_model_inst.desel();
    repeat (3) cache_ctrl_model_inst.idle();
    sleep_request <= 1'b1;
    wr(BASE, 0, 1, 2'h3, BAD);
    repeat (2) cache_ctrl_model_inst.idle();
    sleep_request <= 1'b0;
    rd(BASE, v);
    check("guarded word", v, shadow[0]);
  endtask

  initial begin
    ref_clk         = 1'b0;
    nrst            = 1'b0;
    burstOrderStrap = 1'b0;
    outputEnableN   = 1'b0;
    sleep_request   = 1'b0;
    errCount        = 0;
    nCompared       = 0;
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      shadow[i] = 18'h2_A5C0 ^ (18'(i) * 18'h0_1111);
      wr(BASE + 17'(i), 0, 1, 2'h3, shadow[i]);
    end
    // Write, then let the same burst read that word back
    cache_ctrl_model_inst.cycle(1, 0, 1, 0, 1, 2'h3, SEL, BASE + 3,
                                shadow[3]);
    cache_ctrl_model_inst.cycle(1, 1, 1, 1, 1, 2'h3, SEL, ~BASE, '0);
    rd(BASE + 3, v);
    check("write read", v, shadow[3]);
    burst(3'h0, '{2'h1, 2'h2, 2'h3, 2'h0}, "linear");
    burst(3'h2, '{2'h1, 2'h2, 2'h2, 2'h3}, "stall");
    byte_lanes();
    refused();
    do_reset(1'b1);
    burst(3'h0, '{2'h1, 2'h0, 2'h3, 2'h2}, "interleave");
    test_done();
  end

  // Watchdog: the sequence needs well under 1,000 cycles
  initial begin
    #200000;
    errCount++;
    test_done();
  end
endmodule

// File: verilog/burst_counter.sv
// Two-bit wrapping burst address counter
`timescale 1ns/1ps
`include "sync_sram_regs.svh"
module burst_counter import sync_sram_pkg::*; (
  input  logic         ref_clk,
  input  logic         nrst,
  input  logic         load,
  input  logic         advance,
  input  logic [1:0]   startLow,
  input  burst_order_e order,
  output logic [1:0]   lowAddr
);
  logic [1:0] startReg;
  logic [1:0] beat;
  logic [1:0] next_startReg;
  logic [1:0] next_beat;

  always_comb begin
    next_startReg = load ? startLow : startReg; // R5
    if (load) begin
      next_beat = 2'h0; // R5
    end else if (advance) begin
      next_beat = beat + 2'h1; // R6
    end else begin
      next_beat = beat; // R6
    end
    // Wraps inside a four-word group in both orders
    if (order == ORDER_LINEAR) begin
      lowAddr = next_startReg + next_beat; // R7 R21
    end else begin
      lowAddr = next_startReg ^ next_beat; // R7 R21
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      startReg <= `SRAM_RST_LOW;
      beat     <= `SRAM_RST_LOW;
    end else begin
      startReg <= next_startReg;
      beat     <= next_beat;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_hold_no_advance: assert property ( // R6
    !load && !advance |-> lowAddr == $past(lowAddr))
    else $error("burst address moved without advance");
  a_burst_wrap_four: assert property ( // R21
    (advance && !load)[*4] |-> lowAddr == $past(lowAddr, 4))
    else $error("burst did not wrap after four beats");
endmodule

// File: verilog/sram_array.sv
// Storage array with per-lane writes and registered read
`timescale 1ns/1ps
`include "sync_sram_regs.svh"
module sram_array #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int LANES  = `SRAM_LANES
) (
  input logic          ref_clk,
  input logic          nrst,
  sram_array_if.mem    port
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH  = 1 << ADDR_W;

  if (DATA_W % LANES != 0) begin : g_bad_lanes
    $error("data width must split evenly into lanes");
  end

  logic [DATA_W-1:0] store [DEPTH];
  logic [DATA_W-1:0] readWord;

  // Each lane writes its own slice; one process so the store has one writer
  always_ff @(posedge ref_clk) begin
    for (int g = 0; g < LANES; g++) begin
      if (port.laneWrite[g]) begin
        store[port.addr][g*LANE_W +: LANE_W] <=
          port.wdata[g*LANE_W +: LANE_W]; // R9 R10
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (port.readEn) begin
      readWord <= store[port.addr]; // R2
    end
  end

  assign port.rdata = readWord;

  a_write_then_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    (&port.laneWrite) ##1 (port.readEn && port.laneWrite == '0 &&
    port.addr == $past(port.addr)) |=> port.rdata == $past(port.wdata, 2))
    else $error("read did not return the word just written"); // R2
endmodule

// File: verilog/sram_array_if.sv
// Bundle between the access control and the storage array
`timescale 1ns/1ps
interface sram_array_if #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
);
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0]  laneWrite;
  logic              readEn;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output addr, output wdata, output laneWrite,
                output readEn, input rdata);
  modport mem  (input addr, input wdata, input laneWrite,
                input readEn, output rdata);
endinterface

// File: verilog/sync_burst_sram.sv
// Pipelined burst memory with double-cycle deselect output control
`timescale 1ns/1ps
`include "sync_sram_regs.svh"
module sync_burst_sram import sync_sram_pkg::*; #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int LANES  = `SRAM_LANES
) (
  input  logic              ref_clk,
  input  logic              nrst,
  input  logic [ADDR_W-1:0] address,
  input  logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic              dataOutEnable,
  input  logic              processor_addr_strobe_n,
  input  logic              controller_addr_strobe_n,
  input  logic              burst_advance_n,
  input  logic              global_write_n,
  input  logic              byte_write_enable_n,
  input  logic [LANES-1:0]  lane_write_select_n,
  input  logic              chip_select_first_n,
  input  logic              chip_select_second,
  input  logic              chip_select_third_n,
  input  logic              outputEnableN,
  input  logic              sleep_request,
  input  logic              burstOrderStrap
);
  if (ADDR_W <= `SRAM_BURST_W || LANES != `SRAM_LANES) begin : g_bad_cfg
    $error("unsupported address width or lane count");
  end

  // Input registers
  logic [ADDR_W-1:0] inAddr;
  logic [DATA_W-1:0] inData;
  logic              inProcStrobeN;
  logic              inCtrlStrobeN;
  logic              inAdvanceN;
  logic              inGlobalWriteN;
  logic              inByteWriteN;
  logic [LANES-1:0]  inLaneSelN;
  logic              inSelFirstN;
  logic              inSelSecond;
  logic              inSelThirdN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      inAddr         <= `SRAM_RST_ADDR;
      inData         <= `SRAM_RST_WORD;
      inProcStrobeN  <= 1'b1;
      inCtrlStrobeN  <= 1'b1;
      inAdvanceN     <= 1'b1;
      inGlobalWriteN <= 1'b1;
      inByteWriteN   <= 1'b1;
      inLaneSelN     <= `SRAM_RST_LANE;
      inSelFirstN    <= 1'b1;
      inSelSecond    <= 1'b0;
      inSelThirdN    <= 1'b1;
    end else begin
      inAddr         <= address; // R1
      inData         <= dataIn; // R1
      inProcStrobeN  <= processor_addr_strobe_n; // R1
      inCtrlStrobeN  <= controller_addr_strobe_n; // R1
      inAdvanceN     <= burst_advance_n; // R1
      inGlobalWriteN <= global_write_n; // R1
      inByteWriteN   <= byte_write_enable_n; // R1
      inLaneSelN     <= lane_write_select_n; // R1
      inSelFirstN    <= chip_select_first_n; // R1
      inSelSecond    <= chip_select_second; // R1
      inSelThirdN    <= chip_select_third_n; // R1
    end
  end

  // Burst order strap, synchronised then caught once after reset
  logic         strapSync1;
  logic         strapSync2;
  logic         strapTaken;
  logic [1:0]   strapAge;
  burst_order_e order;
  logic         next_strapTaken;
  logic [1:0]   next_strapAge;
  burst_order_e next_order;

  always_comb begin
    next_strapTaken = strapTaken;
    next_strapAge   = strapAge;
    next_order      = order;
    // Wait until the pin has passed both sync stages
    if (!strapTaken) begin
      next_strapAge = strapAge + 2'h1;
      if (strapAge == 2'h2) begin
        next_strapTaken = 1'b1;
        next_order = strapSync2 ? ORDER_INTERLEAVED : ORDER_LINEAR; // R7 R20
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strapSync1 <= 1'b1;
      strapSync2 <= 1'b1;
      strapTaken <= 1'b0;
      strapAge   <= `SRAM_RST_LOW;
      order      <= ORDER_INTERLEAVED;
    end else begin
      strapSync1 <= burstOrderStrap;
      strapSync2 <= strapSync1;
      strapTaken <= next_strapTaken;
      strapAge   <= next_strapAge;
      order      <= next_order;
    end
  end

  // Access decode on the registered inputs
  burst_state_e                 state;
  burst_state_e                 next_state;
  logic [ADDR_W-1:`SRAM_BURST_W] baseHigh;
  logic [ADDR_W-1:`SRAM_BURST_W] next_baseHigh;
  logic                         csSelected;
  logic                         procTaken;
  logic                         ctrlTaken;
  logic                         strobe;
  logic                         startAccess;
  logic                         continueBurst;
  logic                         cycleValid;
  logic                         advance;
  lane_mask_t                   laneSel;
  logic                         writeNow;
  logic [1:0]                   lowAddr;

  sram_array_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) arr ();

  always_comb begin
    csSelected    = !inSelFirstN && inSelSecond && !inSelThirdN; // R13
    procTaken     = !inProcStrobeN && !inSelFirstN; // R14
    ctrlTaken     = !inCtrlStrobeN && !procTaken; // R18
    strobe        = procTaken || ctrlTaken; // R3
    startAccess   = strobe && csSelected && !sleep_request; // R4 R19
    continueBurst = !strobe && state == BURST_ACTIVE && !sleep_request;
    cycleValid    = startAccess || continueBurst;
    advance       = continueBurst && !inAdvanceN; // R6
    if (!inGlobalWriteN) begin
      laneSel = '1; // R11
    end else if (!inByteWriteN) begin
      laneSel = ~inLaneSelN; // R10 R12
    end else begin
      laneSel = '0;
    end
    // A processor-strobe start is always a read
    writeNow = cycleValid && !(startAccess && procTaken) &&
               laneSel != '0; // R9
    next_baseHigh = startAccess ? inAddr[ADDR_W-1:`SRAM_BURST_W]
                                : baseHigh; // R3 R4
    next_state = state;
    unique case (state)
      BURST_IDLE: begin
        if (startAccess) begin
          next_state = BURST_ACTIVE;
        end
      end
      BURST_ACTIVE: begin
        if (sleep_request || (strobe && !csSelected)) begin
          next_state = BURST_IDLE; // R13 R19
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= BURST_IDLE;
      baseHigh <= '0;
    end else begin
      state    <= next_state;
      baseHigh <= next_baseHigh;
    end
  end

  burst_counter u_counter (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .load     (startAccess),
    .advance  (advance),
    .startLow (inAddr[`SRAM_BURST_W-1:0]),
    .order    (order),
    .lowAddr  (lowAddr)
  );

  assign arr.addr      = {next_baseHigh, lowAddr}; // R5
  assign arr.wdata     = inData; // R9
  assign arr.laneWrite = writeNow ? laneSel : '0; // R9 R19
  assign arr.readEn    = cycleValid && !writeNow; // R8

  sram_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) u_array (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .port    (arr.mem)
  );

  // Output pipeline with one extra drive cycle after the last read
  logic readPipe;
  logic dqDrive;
  logic holdExtra;
  logic oeMask;
  logic next_readPipe;
  logic next_dqDrive;
  logic next_holdExtra;
  logic next_oeMask;
  logic [DATA_W-1:0] next_dataOut;

  always_comb begin
    next_readPipe  = arr.readEn; // R8
    next_dqDrive   = readPipe || (dqDrive && !holdExtra); // R15
    next_holdExtra = dqDrive && !readPipe; // R15
    next_oeMask    = startAccess && state == BURST_IDLE && !writeNow; // R17
    next_dataOut   = readPipe ? arr.rdata : dataOut; // R8
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readPipe  <= 1'b0;
      dqDrive   <= 1'b0;
      holdExtra <= 1'b0;
      oeMask    <= 1'b0;
      dataOut   <= `SRAM_RST_WORD;
    end else begin
      readPipe  <= next_readPipe;
      dqDrive   <= next_dqDrive;
      holdExtra <= next_holdExtra;
      oeMask    <= next_oeMask;
      dataOut   <= next_dataOut;
    end
  end

  // Output enable and sleep gate the drivers without the clock
  assign dataOutEnable = dqDrive && !outputEnableN && !oeMask &&
                         !sleep_request; // R16 R17 R19

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_read_latency: assert property ( // R8
    arr.readEn && !readPipe ##1 !arr.readEn |=> dqDrive ##1 dqDrive)
    else $error("read data not driven on time");
  a_read_data: assert property ( // R8
    readPipe |=> dataOut == $past(arr.rdata))
    else $error("output register missed read data");
  a_drive_extra_on: assert property ( // R15
    $fell(readPipe) |=> dqDrive)
    else $error("drivers dropped without the extra cycle");
  a_drive_then_off: assert property ( // R15
    $fell(readPipe) ##1 !readPipe |=> !dqDrive)
    else $error("drivers stayed on past the extra cycle");
  a_first_select_gate: assert property ( // R14
    !inProcStrobeN && inSelFirstN && inCtrlStrobeN
    |-> !startAccess && (state == BURST_ACTIVE || !writeNow))
    else $error("processor strobe acted with first select high");
  a_proc_strobe_priority: assert property ( // R18
    !inProcStrobeN && !inCtrlStrobeN && !inSelFirstN && csSelected &&
    !sleep_request |-> startAccess && arr.laneWrite == '0)
    else $error("controller strobe acted over processor strobe");
  a_global_write: assert property ( // R11
    cycleValid && !inGlobalWriteN && !(startAccess && procTaken)
    |-> arr.laneWrite == '1)
    else $error("global write missed a lane");
  a_lane_select: assert property ( // R12
    cycleValid && inGlobalWriteN && !(startAccess && procTaken)
    |-> arr.laneWrite == (inByteWriteN ? '0 : ~inLaneSelN))
    else $error("byte write lanes wrong");
  a_deselect_idle: assert property ( // R13
    strobe && !csSelected |=> state == BURST_IDLE)
    else $error("deselect did not end the burst");
  a_sleep_quiet: assert property ( // R16 R19
    sleep_request |-> arr.laneWrite == '0 && !dataOutEnable)
    else $error("activity during sleep");

  c_four_beat_read: cover property (
    startAccess && !writeNow ##1 (advance && !writeNow)[*3]);
  c_global_write: cover property (writeNow && !inGlobalWriteN);
  c_drive_hold: cover property ($fell(readPipe) ##1 dqDrive);
  c_both_strobes: cover property (
    !inProcStrobeN && !inCtrlStrobeN && startAccess);
endmodule

// File: verilog/sync_sram_pkg.sv
// Types shared by the burst memory modules
package sync_sram_pkg;
  typedef enum logic {ORDER_INTERLEAVED, ORDER_LINEAR} burst_order_e;
  typedef enum logic [0:0] {BURST_IDLE, BURST_ACTIVE} burst_state_e;
  typedef logic [1:0] lane_mask_t;
endpackage

// File: verilog/sync_sram_regs.svh
// Constants and function list for the pipelined synchronous burst memory
`ifndef SYNC_SRAM_REGS_SVH
`define SYNC_SRAM_REGS_SVH
// Function
// R1 - Register address, data, selects, strobes, advance and write controls on rising edge.
// R2 - Store 131,072 words of 18 bits on one shared data bus.
// R3 - Latch address and selects only on an edge with an active strobe.
// R4 - Take a new address only with a strobe and all three selects active.
// R5 - Load the low two address bits into the burst counter on latch.
// R6 - Advance the burst address only with advance low, otherwise hold it.
// R7 - Offer interleaved and linear burst orders chosen by the user.
// R8 - Pipeline reads so a four-beat burst runs at 3-1-1-1.
// R9 - Start writes from registered inputs and complete them without further strobes.
// R10 - Write one or both 9-bit lanes as the lane selects choose.
// R11 - Global write low writes every lane, ignoring lane selects and byte enable.
// R12 - Byte write enable low writes only lanes whose selects are low.
// R13 - Select only with first select low, second high, third low.
// R14 - Ignore the processor strobe whenever the first select is high.
// R15 - Keep output drivers on one extra cycle after reads end.
// R16 - Output enable and sleep act without clock sampling.
// R17 - Output enable steers the bus, masked in first clock after deselect; the code masks it in the clock after a read start from idle.
// R18 - With both strobes low, act on the processor strobe only.
// R19 - Sleep high stops activity while keeping stored data.
// R20 - The burst order strap stays static; low means linear order.
// R21 - Bursts wrap in four words: linear adds, interleaved XORs the beat.
`define SRAM_ADDR_W   17
`define SRAM_DATA_W   18
`define SRAM_LANES    2
`define SRAM_BURST_W  2
`define SRAM_RST_ADDR 17'h0_0000
`define SRAM_RST_WORD 18'h0_0000
`define SRAM_RST_LOW  2'h0
`define SRAM_RST_LANE 2'h3
`endif
